/* src/timer_ctl_params.svh */
`ifndef TIMER_CTL_PARAMS_SVH
`define TIMER_CTL_PARAMS_SVH

// byte offsets of the register words
`define OFF_GLOBAL_CONFIGURATION 12'h000
`define OFF_HALF_A_MODE_REGISTER 12'h004
`define OFF_HALF_B_MODE_REGISTER 12'h008
`define OFF_TIMER_CONTROL 12'h00c

// writable bits of each register
`define MASK_GLOBAL_CONFIGURATION 32'h0000_0007
`define MASK_HALF_MODE_REGISTER 32'h0000_000f
`define MASK_TIMER_CONTROL 32'h0000_0f7f

// reset values
`define RST_GLOBAL_CONFIGURATION 3'h0
`define RST_HALF_MODE_REGISTER 4'h0
`define RST_TIMER_CONTROL 12'h000

// global configuration codes
`define CFG_SINGLE32 3'h0
`define CFG_CALENDAR 3'h1
`define CFG_SPLIT_BIT 2

// mode register field
`define MODE_SELECT_LSB 0

// timer control field positions
`define CTL_HALF_B_EDGE_LSB 10
`define CTL_HALF_B_FREEZE 9
`define CTL_HALF_B_ENABLE 8
`define CTL_HALF_A_PWM_INVERT 6
`define CTL_HALF_A_TRIG_ENABLE 5
`define CTL_CALENDAR_ENABLE 4
`define CTL_HALF_A_EDGE_LSB 2
`define CTL_HALF_A_FREEZE 1
`define CTL_HALF_A_ENABLE 0

// capture edge codes
`define EDGE_RISING 2'h0
`define EDGE_FALLING 2'h1
`define EDGE_BOTH 2'h3

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* src/timer_ctl_pkg.sv */
package timer_ctl_pkg;

  typedef enum logic [1:0] {
    cfg_single32,
    cfg_calendar,
    cfg_reserved,
    cfg_split16
  } cfg_kind_t;

  typedef enum logic [1:0] {
    mode_reserved,
    mode_one_shot,
    mode_periodic,
    mode_capture
  } half_mode_t;

  typedef struct packed {
    logic run;
    logic capture_armed;
    half_mode_t mode;
    logic [1:0] edge_sel;
  } half_status_t;

endpackage

/* src/timer_mode_and_control.sv */
`timescale 1ns/1ps
`include "timer_ctl_params.svh"

// Notes on behaviour
// - config picks single, calendar or split timers
// - half B mode: one-shot, periodic, capture
// - split config uses half B mode field
// - single 32-bit config ignores half B mode
// - bits 11:10 pick half B capture edge
// - bit 9 freezes half B on debug halt
// - bit 8 enables half B
// - bit 6 inverts half A pwm output
// - bit 5 gates converter trigger output
// - bit 4 starts and stops calendar counting
// - bits 3:2 pick half A capture edge
// - bit 1 freezes half A on debug halt
// - bit 0 enables half A
module timer_mode_and_control
  import timer_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [11:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [11:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic debug_halt_i,
  input wire logic half_a_pwm_raw_i,
  input wire logic half_a_trigger_raw_i,
  input wire logic [1:0] capture_pin_i,
  output half_status_t half_a_status_o,
  output half_status_t half_b_status_o,
  output cfg_kind_t cfg_kind_o,
  output logic calendar_run_o,
  output logic half_a_pwm_o,
  output logic half_a_converter_trigger_o,
  output logic [1:0] capture_event_o
);

  // register contents
  logic [2:0] global_configuration;
  logic [3:0] half_a_mode_register;
  logic [3:0] half_b_mode_register;
  logic [11:0] timer_control;

  // write channel state
  logic aw_held;
  logic [11:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // merge of byte lanes under the write strobes
  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old_word;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ---------------- write address and data acceptance
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire have_aw = aw_held | aw_take;
  wire have_w = w_held | w_take;
  // a response still waiting holds off the next write, so bresp is never overwritten
  wire do_write = have_aw & have_w & ~s_axi_bvalid_o;
  wire [11:0] wr_addr = aw_take ? s_axi_awaddr_i : aw_addr;
  wire [31:0] wr_data = w_take ? s_axi_wdata_i : w_data;
  wire [3:0] wr_strb = w_take ? s_axi_wstrb_i : w_strb;
  // address bits 1:0 are ignored: every register is one aligned word
  wire [11:0] wr_word = {wr_addr[11:2], 2'b00};

  wire wr_sel_cfg = (wr_word == `OFF_GLOBAL_CONFIGURATION);
  wire wr_sel_mode_a = (wr_word == `OFF_HALF_A_MODE_REGISTER);
  wire wr_sel_mode_b = (wr_word == `OFF_HALF_B_MODE_REGISTER);
  wire wr_sel_ctl = (wr_word == `OFF_TIMER_CONTROL);
  wire wr_hit = wr_sel_cfg | wr_sel_mode_a | wr_sel_mode_b | wr_sel_ctl;

  wire next_aw_held = do_write ? 1'b0 : have_aw;
  wire next_w_held = do_write ? 1'b0 : have_w;
  wire next_bvalid = do_write | (s_axi_bvalid_o & ~s_axi_bready_i);
  wire next_awready = ~next_aw_held & ~next_bvalid;
  wire next_wready = ~next_w_held & ~next_bvalid;
  wire [1:0] next_bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= wr_addr;
      w_data <= wr_data;
      w_strb <= wr_strb;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `RESP_OKAY;
    end else begin
      s_axi_awready_o <= next_awready;
      s_axi_wready_o <= next_wready;
      s_axi_bvalid_o <= next_bvalid;
      if (do_write) begin
        s_axi_bresp_o <= next_bresp;
      end
    end
  end

  // ---------------- register updates, reserved bits masked off
  wire [31:0] cfg_merged = merge_lanes({29'h0, global_configuration}, wr_data, wr_strb);
  wire [31:0] mode_a_merged = merge_lanes({28'h0, half_a_mode_register}, wr_data, wr_strb);
  wire [31:0] mode_b_merged = merge_lanes({28'h0, half_b_mode_register}, wr_data, wr_strb);
  wire [31:0] ctl_merged = merge_lanes({20'h0, timer_control}, wr_data, wr_strb);
  wire [31:0] cfg_masked = cfg_merged & `MASK_GLOBAL_CONFIGURATION;
  wire [31:0] mode_a_masked = mode_a_merged & `MASK_HALF_MODE_REGISTER;
  wire [31:0] mode_b_masked = mode_b_merged & `MASK_HALF_MODE_REGISTER;
  wire [31:0] ctl_masked = ctl_merged & `MASK_TIMER_CONTROL;

  // the select wires are one-hot, so a write touches one word only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      global_configuration <= `RST_GLOBAL_CONFIGURATION;
      half_a_mode_register <= `RST_HALF_MODE_REGISTER;
    end else if (do_write) begin
      if (wr_sel_cfg) begin
        global_configuration <= cfg_masked[2:0];
      end
      if (wr_sel_mode_a) begin
        half_a_mode_register <= mode_a_masked[3:0];
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_b_mode_register <= `RST_HALF_MODE_REGISTER;
      timer_control <= `RST_TIMER_CONTROL;
    end else if (do_write) begin
      if (wr_sel_mode_b) begin
        half_b_mode_register <= mode_b_masked[3:0];
      end
      if (wr_sel_ctl) begin
        timer_control <= ctl_masked[11:0];
      end
    end
  end

  // ---------------- read channel
  wire ar_take = s_axi_arvalid_i & s_axi_arready_o;
  wire [11:0] rd_word = {s_axi_araddr_i[11:2], 2'b00};
  wire rd_sel_cfg = (rd_word == `OFF_GLOBAL_CONFIGURATION);
  wire rd_sel_mode_a = (rd_word == `OFF_HALF_A_MODE_REGISTER);
  wire rd_sel_mode_b = (rd_word == `OFF_HALF_B_MODE_REGISTER);
  wire rd_sel_ctl = (rd_word == `OFF_TIMER_CONTROL);
  wire rd_hit = rd_sel_cfg | rd_sel_mode_a | rd_sel_mode_b | rd_sel_ctl;
  wire [31:0] rd_value =
    ({32{rd_sel_cfg}} & {29'h0, global_configuration}) |
    ({32{rd_sel_mode_a}} & {28'h0, half_a_mode_register}) |
    ({32{rd_sel_mode_b}} & {28'h0, half_b_mode_register}) |
    ({32{rd_sel_ctl}} & {20'h0, timer_control});
  wire next_rvalid = ar_take | (s_axi_rvalid_o & ~s_axi_rready_i);
  wire next_arready = ~next_rvalid;
  wire [1:0] next_rresp = rd_hit ? `RESP_OKAY : `RESP_SLVERR;

  // address decoded at the handshake edge; rdata then stands until rready

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `RESP_OKAY;
    end else begin
      s_axi_arready_o <= next_arready;
      s_axi_rvalid_o <= next_rvalid;
      if (ar_take) begin
        s_axi_rdata_o <= rd_value;
        s_axi_rresp_o <= next_rresp;
      end
    end
  end

  // ---------------- configuration decode
  // arrangement select
  // configs 2 and 3 are reserved: neither half runs or arms there
  wire is_split = global_configuration[`CFG_SPLIT_BIT];
  wire is_single = (global_configuration == `CFG_SINGLE32);
  wire is_calendar = (global_configuration == `CFG_CALENDAR);
  wire cfg_kind_t next_cfg_kind = is_split ? cfg_split16 :
                                  is_single ? cfg_single32 :
                                  is_calendar ? cfg_calendar : cfg_reserved;

  wire half_mode_t mode_b_field = half_mode_t'(half_b_mode_register[`MODE_SELECT_LSB +: 2]);
  wire half_mode_t mode_a_field = half_mode_t'(half_a_mode_register[`MODE_SELECT_LSB +: 2]);
  wire half_mode_t next_mode_b = is_split ? mode_b_field : mode_reserved;
  wire half_mode_t next_mode_a = (is_single | is_split) ? mode_a_field : mode_reserved;

  // ---------------- control bit decode
  // half A enable
  wire en_a = timer_control[`CTL_HALF_A_ENABLE];
  wire en_b = timer_control[`CTL_HALF_B_ENABLE];
  wire freeze_a = debug_halt_i & timer_control[`CTL_HALF_A_FREEZE];
  wire freeze_b = debug_halt_i & timer_control[`CTL_HALF_B_FREEZE];
  wire [1:0] edge_a = timer_control[`CTL_HALF_A_EDGE_LSB +: 2];
  wire [1:0] edge_b = timer_control[`CTL_HALF_B_EDGE_LSB +: 2];
  wire cal_en = timer_control[`CTL_CALENDAR_ENABLE];
  wire pwm_invert = timer_control[`CTL_HALF_A_PWM_INVERT];
  wire trig_en = timer_control[`CTL_HALF_A_TRIG_ENABLE];

  // capture mode stops a half counting; it arms the half only in the split config
  wire next_run_a = en_a & ~freeze_a & (is_single | is_split) & (mode_a_field != mode_capture);
  wire next_run_b = en_b & ~freeze_b & is_split & (mode_b_field != mode_capture);
  wire next_arm_a = en_a & is_split & (mode_a_field == mode_capture);
  wire next_arm_b = en_b & is_split & (mode_b_field == mode_capture);
  // calendar counts with half A on
  wire next_calendar_run = is_calendar & en_a & cal_en & ~freeze_a;

  // status words, one field to a line
  wire half_status_t next_status_a = '{
    run: next_run_a,
    capture_armed: next_arm_a,
    mode: next_mode_a,
    edge_sel: edge_a
  };
  wire half_status_t next_status_b = '{
    run: next_run_b,
    capture_armed: next_arm_b,
    mode: next_mode_b,
    edge_sel: edge_b
  };

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_a_status_o <= '0;
      half_b_status_o <= '0;
      cfg_kind_o <= cfg_single32;
      calendar_run_o <= 1'b0;
    end else begin
      half_a_status_o <= next_status_a;
      half_b_status_o <= next_status_b;
      cfg_kind_o <= next_cfg_kind;
      calendar_run_o <= next_calendar_run;
    end
  end

  // ---------------- half A outputs
  // converter must also pick this source
  // both outputs follow their raw input one cycle later
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      half_a_pwm_o <= 1'b0;
      half_a_converter_trigger_o <= 1'b0;
    end else begin
      half_a_pwm_o <= half_a_pwm_raw_i ^ pwm_invert;
      half_a_converter_trigger_o <= half_a_trigger_raw_i & trig_en;
    end
  end

  // ---------------- capture edge detection per half
  wire [1:0] arm_vec = {next_arm_b, next_arm_a};
  wire [1:0] frz_vec = {freeze_b, freeze_a};
  wire [3:0] edge_vec = {edge_b, edge_a};

  // pins are asynchronous: edge logic reads the second and third flops, never the first
  // prev resets low; arm is clear after reset, so no false edge escapes
  for (genvar i = 0; i < 2; i++) begin : g_capture
    logic sync_1;
    logic sync_2;
    logic prev;
    logic evt;
    wire rise = sync_2 & ~prev;
    wire fall = ~sync_2 & prev;
    wire [1:0] sel = edge_vec[i*2 +: 2];
    // edge choice, reserved code never fires
    wire hit = (sel == `EDGE_RISING) ? rise :
               (sel == `EDGE_FALLING) ? fall :
               (sel == `EDGE_BOTH) ? (rise | fall) : 1'b0;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        sync_1 <= 1'b0;
        sync_2 <= 1'b0;
        prev <= 1'b0;
        evt <= 1'b0;
      end else begin
        sync_1 <= capture_pin_i[i];
        sync_2 <= sync_1;
        prev <= sync_2;
        evt <= hit & arm_vec[i] & ~frz_vec[i];
      end
    end

    assign capture_event_o[i] = evt;
  end

endmodule

/* testbench/tmc_monitor.sv */
`timescale 1ns/1ps
module tmc_monitor
  import timer_ctl_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic s_axi_bvalid_o,
  input wire logic debug_halt_i,
  input wire logic half_a_pwm_raw_i,
  input wire logic half_a_trigger_raw_i,
  input wire half_status_t half_a_status_o,
  input wire half_status_t half_b_status_o,
  input wire cfg_kind_t cfg_kind_o,
  input wire logic calendar_run_o,
  input wire logic half_a_pwm_o,
  input wire logic half_a_converter_trigger_o,
  input wire logic [1:0] capture_event_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  logic pwm_q;
  logic trig_q;
  wire pwm_flip = half_a_pwm_o ^ pwm_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwm_q <= 1'b0;
      trig_q <= 1'b0;
    end else begin
      pwm_q <= half_a_pwm_raw_i;
      trig_q <= half_a_trigger_raw_i;
    end
  end
  sequence both_taken;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  a_write_answer: assert property (both_taken |=> s_axi_bvalid_o)
    else $error("write answer late");
  a_pwm_invert: assert property ($changed(pwm_flip) |-> $past(s_axi_bvalid_o))
    else $error("pwm polarity changed without a write");
  a_trigger_gate: assert property (half_a_converter_trigger_o |-> trig_q)
    else $error("trigger without raw trigger");
  a_freeze_a: assert property ($fell(half_a_status_o.run) |-> $past(debug_halt_i) || $past(s_axi_bvalid_o))
    else $error("half a stopped without cause");
  a_freeze_b: assert property ($fell(half_b_status_o.run) |-> $past(debug_halt_i) || $past(s_axi_bvalid_o))
    else $error("half b stopped without cause");
  a_calendar_cfg: assert property (calendar_run_o |-> cfg_kind_o == cfg_calendar && !half_a_status_o.run)
    else $error("calendar runs outside its config");
  a_b_ignored: assert property (cfg_kind_o != cfg_split16 |-> half_b_status_o[5:2] == 4'h0)
    else $error("half b active outside split config");
  a_b_mode: assert property (half_b_status_o.run |-> half_b_status_o.mode != mode_capture)
    else $error("half b runs in capture mode");
  a_b_capture: assert property (capture_event_o[1] |-> half_b_status_o.capture_armed)
    else $error("half b event while not armed");
  a_a_capture: assert property (capture_event_o[0] |-> half_a_status_o.capture_armed)
    else $error("half a event while not armed");
endmodule
bind timer_mode_and_control tmc_monitor mon (.clk_i, .arst_n_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .debug_halt_i, .half_a_pwm_raw_i,
  .half_a_trigger_raw_i, .half_a_status_o, .half_b_status_o, .cfg_kind_o, .calendar_run_o,
  .half_a_pwm_o, .half_a_converter_trigger_o, .capture_event_o);

/* testbench/conv_model.sv */
`timescale 1ns/1ps
module conv_model (
  input wire logic trigger_i,
  input wire logic enable_i,
  input wire logic source_sel_i,
  output logic start_o
);
  assign start_o = trigger_i & enable_i & source_sel_i;
endmodule

/* testbench/tb_timer_mode_and_control.sv */
`timescale 1ns/1ps
module tb_timer_mode_and_control
  import timer_ctl_pkg::*;
;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [11:0] awaddr = 12'h0;
  logic [11:0] araddr = 12'h0;
  logic [31:0] wdata = 32'h0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic halt = 1'b0, pwm_raw = 1'b0, trig_raw = 1'b0, adc_on = 1'b0;
  logic [1:0] cap = 2'h0;
  logic [1:0] cap_d1 = 2'h0, cap_d2 = 2'h0, cap_d3 = 2'h0, cap_d4 = 2'h0;
  logic [3:0] strb = 4'hf;
  logic src_sel = 1'b0;
  logic awrdy, wrdy, bvalid, arrdy, rvalid, cal, pwm, trg, start, pwm_q, trig_q;
  logic [1:0] bresp, rresp, cev;
  logic [31:0] rdata;
  half_status_t sa, sb;
  cfg_kind_t ck;
  int seed = 79473;
  int num_errors = 0;
  int checks = 0;

  timer_mode_and_control dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .s_axi_awaddr_i(awaddr),
    .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awv), .s_axi_awready_o(awrdy), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arprot_i(3'h0),
    .s_axi_arvalid_i(arv), .s_axi_arready_o(arrdy), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .debug_halt_i(halt), .half_a_pwm_raw_i(pwm_raw),
    .half_a_trigger_raw_i(trig_raw), .capture_pin_i(cap), .half_a_status_o(sa), .half_b_status_o(sb),
    .cfg_kind_o(ck), .calendar_run_o(cal), .half_a_pwm_o(pwm), .half_a_converter_trigger_o(trg),
    .capture_event_o(cev));
  conv_model conv (.trigger_i(trg), .enable_i(adc_on), .source_sel_i(src_sel), .start_o(start));

  initial forever #25 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    pwm_raw <= 1'($random(seed));
    trig_raw <= 1'($random(seed));
    cap <= 2'($random(seed));
    pwm_q <= pwm_raw;
    trig_q <= trig_raw;
    cap_d1 <= cap;
    cap_d2 <= cap_d1;
    cap_d3 <= cap_d2;
    cap_d4 <= cap_d3;
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
    end while (!bvalid && n < 40);
    bready <= 1'b0;
    chk("bvalid", {31'h0, bvalid}, 32'h1);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
    @(posedge clk_i);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
      if (arv && arrdy) arv <= 1'b0;
    end while (!rvalid && n < 40);
    rready <= 1'b0;
    chk("rvalid", {31'h0, rvalid}, 32'h1);
    chk("rdata", rdata, ed);
    chk("rresp", {30'h0, rresp}, {30'h0, er});
    @(posedge clk_i);
  endtask

  function automatic logic [3:0] hx(logic en, logic fz, logic [1:0] m, logic ok, logic sp);
    hx = {en & !fz & ok & (m != 2'h3), en & sp & (m == 2'h3), ok ? m : 2'h0};
  endfunction

  function automatic logic ev(logic [1:0] s, logic n, logic o, logic armed);
    ev = armed & ((s == 2'h0) ? (n & !o) : (s == 2'h1) ? (!n & o) : (s == 2'h3) ? (n ^ o) : 1'b0);
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    test_done;
  end

  initial begin
    logic [31:0] c, a, b, t;
    logic sp, h;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    @(posedge clk_i);
    for (int i = 0; i < 4; i++) rd(12'(i * 4), 32'h0, 2'h0);
    rd(12'h010, 32'h0, 2'h2);
    wr(12'h010, 32'hffff_ffff, 2'h2);
    strb <= 4'h2;
    wr(12'h00c, 32'hffff_ffff, 2'h0);
    strb <= 4'hf;
    rd(12'h00c, 32'h0000_0f00, 2'h0);
    $display("test map done");
    for (int i = 0; i < 24; i++) begin
      c = $random(seed);
      if (i < 8) c[2:0] = i[2:0];
      a = $random(seed);
      b = $random(seed);
      t = $random(seed);
      h = (i % 3 == 0);
      wr(12'h000, c, 2'h0);
      wr(12'h004, a, 2'h0);
      wr(12'h008, b, 2'h0);
      wr(12'h00c, t, 2'h0);
      rd(12'h000, c & 32'h7, 2'h0);
      rd(12'h004, a & 32'hf, 2'h0);
      rd(12'h008, b & 32'hf, 2'h0);
      rd(12'h00c, t & 32'hf7f, 2'h0);
      halt <= h;
      adc_on <= t[7];
      src_sel <= t[31];
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      sp = c[2];
      chk("cfg_kind", ck, sp ? 2'h3 : (c[2:0] > 3'h1 ? 2'h2 : c[1:0]));
      chk("half_a", sa[5:2], hx(t[0], h & t[1], a[1:0], sp | (c[2:0] == 3'h0), sp));
      chk("half_b", sb[5:2], hx(t[8], h & t[9], b[1:0], sp, sp));
      chk("calendar", cal, c[2:0] == 3'h1 & t[0] & t[4] & !(h & t[1]));
      chk("pwm", pwm, pwm_q ^ t[6]);
      chk("trigger", trg, trig_q & t[5]);
      chk("conv_start", start, trig_q & t[5] & t[7] & t[31]);
      chk("edge_a", sa[1:0], t[3:2]);
      chk("edge_b", sb[1:0], t[11:10]);
      chk("capture_a", cev[0], ev(t[3:2], cap_d3[0], cap_d4[0],
        t[0] & sp & (a[1:0] == 2'h3) & !(h & t[1])));
      chk("capture_b", cev[1], ev(t[11:10], cap_d3[1], cap_d4[1],
        t[8] & sp & (b[1:0] == 2'h3) & !(h & t[9])));
      @(posedge clk_i);
    end
    $display("test random done");
    test_done;
  end
endmodule
